// >>> design/vcb_top.sv
// virtual counter bank manager: processor port, counters, sram paging
`timescale 1ns/10ps
// Overview of operation
// RULE1 - 64 counters in four banks of sixteen, each with own source.
// RULE2 - up to 64K virtual counters; inactive banks live in external SRAM.
// RULE3 - swap stores bank to home, then loads it from commanded location.
// RULE4 - store copies bank to home, counters left unchanged.
// RULE5 - load fills bank from commanded location, overwriting it.
// RULE6 - per-bank register holds home address and valid flag, read/write.
// RULE7 - writing a bank register always sets its valid flag.
// RULE8 - only the invalidate command clears a valid flag.
// RULE9 - invalid bank: store ignored, swap skips store, still loads.
// RULE10 - counters are 32-bit, even/odd pairs may form 64-bit.
// RULE11 - 64-bit data; unused read bits are one, unused write bits ignored.
// RULE12 - local field is 12 address bits above the two byte bits.
// RULE13 - outside decoder gates base address into the strobes.
// RULE14 - top four local bits are the command; codes 0 to 5 defined.
// RULE15 - command 0 uses low eight bits as sparse operation selector.
// RULE16 - commands 1, 2, 4 address one counter by bank and index.
// RULE17 - commands 3, 5 are bank operations: bank and operation nibbles.
// RULE18 - processor starts by pulling read or write strobe low.
// RULE19 - device pulls acknowledge low when the action is done.
// RULE20 - processor releases strobe before acknowledge goes low.
// RULE21 - start qualifier gates interactions; may pulse under held strobes.
// RULE22 - acknowledge lasts one clock; write done at acknowledge.
// RULE23 - hold asserted before acknowledge keeps data and acknowledge.
// RULE24 - inputs sampled and acknowledge driven on rising clock edges.
// RULE25 - bank commands acknowledge only after all sixteen transfers.
module vcb_top #(
  parameter int DIV = vcb_pkg::TICK_DIV
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic start_qualifier_n,
  input wire logic hold_request_n,
  input wire logic [vcb_pkg::ADDR_W-1:0] addr,
  input wire logic [vcb_pkg::DATA_W-1:0] wr_data,
  output logic [vcb_pkg::DATA_W-1:0] rd_data,
  output logic acknowledge_n,
  input wire logic [vcb_pkg::NUM_CNT-1:0] cnt_ext,
  output logic [vcb_pkg::SRAM_AW-1:0] sram_addr,
  output logic [vcb_pkg::CNT_W-1:0] sram_wdata,
  output logic sram_we,
  output logic sram_re,
  input wire logic [vcb_pkg::CNT_W-1:0] sram_rdata
);
  typedef struct packed {
    vcb_pkg::vcb_state_t fsm;
    logic ack_n;
    logic [63:0] rd;
    logic [3:0][11:0] home;
    logic [3:0] valid;
    logic [63:0][3:0] cfg;
    logic [1:0] bank;
    logic [3:0] idx;
    logic [11:0] loc;
    logic do_load;
    logic [15:0] sram_addr;
    logic [31:0] sram_wdata;
    logic sram_we;
    logic sram_re;
    logic req_prev;
    logic [63:0] ext_prev;
    logic [63:0] sw_inc;
    logic soft_clr;
    logic [15:0] div_cnt;
    logic tick;
  } vcb_top_t;

  vcb_top_t q;
  vcb_top_t d;

  // sram word address: home bank in the top, counter index below
  function automatic logic [15:0] fn_sram_addr(input logic [11:0] home,
                                               input logic [3:0] idx);
    fn_sram_addr = {home, idx};
  endfunction

  logic [11:0] loc_field;
  logic [3:0] cmd;
  logic [7:0] lo;
  logic [3:0] bsel;
  logic [3:0] nsel;
  logic bank_ok;
  logic req_now;
  logic take;
  logic is_wr;
  logic [3:0][15:0][31:0] cnt_all;
  logic [63:0] inc;
  logic [3:0] bank_wr_en;
  logic [3:0] bank_wr_idx;
  logic [31:0] bank_wr_val;
  logic take_inval;
  logic take_breg_rd;
  logic take_store;
  logic take_load;

  // address split; byte bits are ignored
  assign loc_field = addr[vcb_pkg::LOC_MSB:vcb_pkg::LOC_LSB]; // RULE12
  assign cmd = loc_field[11:8]; // RULE14
  assign lo = loc_field[7:0];
  assign bsel = lo[7:4]; // RULE16 RULE17
  assign nsel = lo[3:0];
  assign bank_ok = (bsel[3:2] == 2'h0);
  assign is_wr = !write_strobe_n;

  // a request starts on the edge of strobe-and-qualifier, so a pulsed
  // qualifier under a held strobe gives one request per pulse
  assign req_now = !start_qualifier_n
                   && (!read_strobe_n || !write_strobe_n); // RULE18 RULE21
  assign take = req_now && !q.req_prev
                && q.fsm == vcb_pkg::S_IDLE; // RULE21 RULE24

  // assertion helpers
  assign take_inval = take && is_wr && cmd == vcb_pkg::CMD_BANKOP
                      && bank_ok && nsel == vcb_pkg::OP_INVAL;
  assign take_breg_rd = take && !is_wr && cmd == vcb_pkg::CMD_BANKREG;
  assign take_store = take && is_wr && cmd == vcb_pkg::CMD_BANKOP
                      && bank_ok && nsel == vcb_pkg::OP_STORE
                      && q.valid[bsel[1:0]];
  assign take_load = take && is_wr && cmd == vcb_pkg::CMD_BANKOP
                     && bank_ok && nsel == vcb_pkg::OP_LOAD;

  // per-counter source selection
  always_comb
  begin
    inc = '0;
    for (int i = 0; i < vcb_pkg::NUM_CNT; i++)
    begin
      case (q.cfg[i][vcb_pkg::CFG_SRC_LSB +: 2]) // RULE1
        vcb_pkg::SRC_NODE: inc[i] = 1'b1;
        vcb_pkg::SRC_EXT: inc[i] = cnt_ext[i] && !q.ext_prev[i];
        vcb_pkg::SRC_SW: inc[i] = q.sw_inc[i];
        default: inc[i] = q.tick;
      endcase
      inc[i] = inc[i] && q.cfg[i][vcb_pkg::CFG_EN_BIT];
    end
  end

  // main sequencer: command decode, sram paging, acknowledge
  always_comb
  begin
    d = q;
    d.sram_we = 1'b0;
    d.sram_re = 1'b0;
    d.sw_inc = '0;
    d.soft_clr = 1'b0;
    d.req_prev = req_now;
    d.ext_prev = cnt_ext;
    d.tick = 1'b0;
    bank_wr_en = '0;
    bank_wr_idx = nsel;
    bank_wr_val = wr_data[31:0];
    // slow tick enable for the divided source
    if (q.div_cnt == 16'(DIV - 1))
    begin
      d.div_cnt = '0;
      d.tick = 1'b1;
    end
    else
      d.div_cnt = q.div_cnt + 16'h1;
    case (q.fsm)
      vcb_pkg::S_IDLE:
        if (take)
        begin
          d.ack_n = 1'b0; // RULE19 RULE22
          d.fsm = vcb_pkg::S_ACK;
          d.rd = '1; // RULE11
          d.bank = bsel[1:0];
          case (cmd)
            vcb_pkg::CMD_GEN:
              if (is_wr && lo == vcb_pkg::OP_SOFT_RESET) // RULE15
              begin
                d.cfg = '0;
                d.soft_clr = 1'b1;
              end
            vcb_pkg::CMD_CNT:
              if (bank_ok && is_wr)
                bank_wr_en[bsel[1:0]] = 1'b1;
              else if (bank_ok)
              begin
                d.rd[31:0] = cnt_all[bsel[1:0]][nsel];
                // paired even counter reads as one 64-bit value
                if (!nsel[0]
                    && q.cfg[{bsel[1:0], nsel}][vcb_pkg::CFG_PAIR_BIT])
                  d.rd[63:32] = cnt_all[bsel[1:0]][{nsel[3:1], 1'b1}];
                  // RULE10
              end
            vcb_pkg::CMD_CFG:
              if (bank_ok && is_wr)
                d.cfg[{bsel[1:0], nsel}] = wr_data[3:0]; // RULE11
              else if (bank_ok)
                d.rd[3:0] = q.cfg[{bsel[1:0], nsel}];
            vcb_pkg::CMD_SWTRIG:
              if (bank_ok && is_wr)
                d.sw_inc[{bsel[1:0], nsel}] = 1'b1;
            vcb_pkg::CMD_BANKREG:
              if (bank_ok && is_wr)
              begin
                d.home[bsel[1:0]] = wr_data[11:0]; // RULE6
                d.valid[bsel[1:0]] = 1'b1; // RULE7
              end
              else if (bank_ok)
              begin
                d.rd[11:0] = q.home[bsel[1:0]]; // RULE6
                d.rd[vcb_pkg::VALID_BIT] = q.valid[bsel[1:0]];
              end
            vcb_pkg::CMD_BANKOP:
              if (bank_ok && is_wr)
              begin
                d.loc = wr_data[11:0]; // RULE2
                d.idx = '0;
                d.do_load = (nsel == vcb_pkg::OP_SWAP)
                            || (nsel == vcb_pkg::OP_LOAD);
                case (nsel)
                  vcb_pkg::OP_SWAP,
                  vcb_pkg::OP_STORE:
                    // invalid bank skips the store phase
                    if (q.valid[bsel[1:0]]) // RULE9
                    begin
                      d.fsm = vcb_pkg::S_STORE;
                      d.ack_n = 1'b1; // RULE25
                    end
                    else if (nsel == vcb_pkg::OP_SWAP)
                    begin
                      d.fsm = vcb_pkg::S_LD_REQ;
                      d.ack_n = 1'b1;
                    end
                  vcb_pkg::OP_LOAD:
                  begin
                    d.fsm = vcb_pkg::S_LD_REQ; // RULE5
                    d.ack_n = 1'b1;
                  end
                  vcb_pkg::OP_INVAL:
                    d.valid[bsel[1:0]] = 1'b0; // RULE8
                  default: ;
                endcase
              end
            default: ;
          endcase
        end
      vcb_pkg::S_STORE:
      begin
        // bank image goes to its home, counters keep running
        d.sram_we = 1'b1; // RULE3 RULE4
        d.sram_addr = fn_sram_addr(q.home[q.bank], q.idx);
        d.sram_wdata = cnt_all[q.bank][q.idx];
        d.idx = q.idx + 4'h1;
        if (q.idx == 4'hf)
          d.fsm = q.do_load ? vcb_pkg::S_LD_REQ : vcb_pkg::S_FIN;
      end
      vcb_pkg::S_LD_REQ:
      begin
        // async sram: data valid while read enable is high
        d.sram_re = 1'b1; // RULE3 RULE5
        d.sram_addr = fn_sram_addr(q.loc, q.idx);
        d.fsm = vcb_pkg::S_LD_CAP;
      end
      vcb_pkg::S_LD_CAP:
      begin
        bank_wr_en[q.bank] = 1'b1; // RULE5
        bank_wr_idx = q.idx;
        bank_wr_val = sram_rdata;
        d.idx = q.idx + 4'h1;
        d.fsm = (q.idx == 4'hf) ? vcb_pkg::S_FIN : vcb_pkg::S_LD_REQ;
        if (q.idx == 4'hf)
        begin
          // loaded image now owns the bank; writing home marks it valid
          d.home[q.bank] = q.loc;
          d.valid[q.bank] = 1'b1;
        end
      end
      vcb_pkg::S_FIN:
      begin
        d.ack_n = 1'b0; // RULE25
        d.fsm = vcb_pkg::S_ACK;
      end
      vcb_pkg::S_ACK:
        // one-cycle acknowledge unless hold asks to stretch it
        if (hold_request_n) // RULE22 RULE23
        begin
          d.ack_n = 1'b1;
          d.fsm = vcb_pkg::S_IDLE;
        end
      default:
        d.fsm = vcb_pkg::S_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.ack_n <= 1'b1;
      q.rd <= '1;
    end
    else
      q <= d; // RULE24
  end

  // four counter banks
  for (genvar b = 0; b < vcb_pkg::NUM_BANKS; b++)
  begin : g_bank
    logic [7:0] pair_b;
    for (genvar p = 0; p < 8; p++)
    begin : g_pair
      assign pair_b[p] = q.cfg[b * 16 + 2 * p][vcb_pkg::CFG_PAIR_BIT];
    end
    vcb_counter_bank u_bank (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clr(q.soft_clr),
      .inc(inc[b * 16 +: 16]),
      .pair(pair_b), // RULE10
      .wr_en(bank_wr_en[b]),
      .wr_idx(bank_wr_idx),
      .wr_val(bank_wr_val),
      .cnt(cnt_all[b])
    );
  end

  assign rd_data = q.rd;
  assign acknowledge_n = q.ack_n;
  assign sram_addr = q.sram_addr;
  assign sram_wdata = q.sram_wdata;
  assign sram_we = q.sram_we;
  assign sram_re = q.sram_re;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_ACK_ONE: assert property ( // RULE22
    $fell(acknowledge_n) && hold_request_n |=> acknowledge_n)
    else $error("acknowledge longer than one cycle without hold");
  AST_ACK_HOLD: assert property ( // RULE23
    !acknowledge_n && !hold_request_n |=> !acknowledge_n && $stable(rd_data))
    else $error("acknowledge or data dropped under hold");
  AST_VALID_SET: assert property ( // RULE7
    take && is_wr && cmd == vcb_pkg::CMD_BANKREG && bank_ok
    |=> q.valid[$past(bsel[1:0])])
    else $error("bank register write did not set valid");
  AST_VALID_CLR: assert property ( // RULE8
    (q.valid & ~$past(q.valid)) == 4'h0 && (~q.valid & $past(q.valid)) != 4'h0
    |-> $past(take_inval))
    else $error("valid cleared without invalidate");
  AST_STORE_VALID: assert property ( // RULE9
    sram_we |-> q.valid[q.bank] && sram_addr[15:4] == q.home[q.bank])
    else $error("store to sram from invalid bank or wrong home");
  AST_UNUSED_ONES: assert property ( // RULE11
    take_breg_rd |=> rd_data[63:13] == '1 && !acknowledge_n)
    else $error("unused read bits not one");
  AST_STORE_ACK: assert property ( // RULE25
    take_store |=> acknowledge_n[*8] ##10 !acknowledge_n)
    else $error("store acknowledge timing wrong");
  AST_LOAD_ACK: assert property ( // RULE5
    take_load |-> ##34 !acknowledge_n ##0 $past(acknowledge_n))
    else $error("load acknowledge timing wrong");
  AST_TAKE_GATED: assert property ( // RULE21
    start_qualifier_n && q.fsm == vcb_pkg::S_IDLE |=> q.fsm == vcb_pkg::S_IDLE)
    else $error("interaction started with qualifier deasserted");
endmodule // vcb_top

// >>> design/vcb_pkg.sv
// shared constants and types of the virtual counter bank manager
package vcb_pkg;
  localparam int NUM_BANKS = 4;
  localparam int CNT_PER_BANK = 16;
  localparam int NUM_CNT = 64;
  localparam int CNT_W = 32;
  localparam int DATA_W = 64;
  localparam int ADDR_W = 14;
  localparam int HOME_W = 12;
  localparam int SRAM_AW = 16;
  localparam int CFG_W = 4;
  // local address field sits above the two byte bits
  localparam int LOC_LSB = 2;
  localparam int LOC_MSB = 13;
  // command codes in the top nibble of the local field
  localparam logic [3:0] CMD_GEN = 4'h0;
  localparam logic [3:0] CMD_CNT = 4'h1;
  localparam logic [3:0] CMD_CFG = 4'h2;
  localparam logic [3:0] CMD_BANKREG = 4'h3;
  localparam logic [3:0] CMD_SWTRIG = 4'h4;
  localparam logic [3:0] CMD_BANKOP = 4'h5;
  // general operations and bank operations
  localparam logic [7:0] OP_SOFT_RESET = 8'h00;
  localparam logic [3:0] OP_SWAP = 4'h0;
  localparam logic [3:0] OP_STORE = 4'h1;
  localparam logic [3:0] OP_LOAD = 4'h2;
  localparam logic [3:0] OP_INVAL = 4'h3;
  // counter configuration fields
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_EN_BIT = 2;
  localparam int CFG_PAIR_BIT = 3;
  localparam logic [1:0] SRC_NODE = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_SW = 2'h2;
  localparam logic [1:0] SRC_TICK = 2'h3;
  // bank register read layout
  localparam int VALID_BIT = 12;
  localparam int TICK_DIV = 10;
  typedef enum logic [2:0] {
    S_IDLE, S_STORE, S_LD_REQ, S_LD_CAP, S_FIN, S_ACK
  } vcb_state_t;
endpackage

// >>> design/vcb_counter_bank.sv
// one bank of sixteen counters with even/odd pairing
`timescale 1ns/10ps
module vcb_counter_bank (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic [15:0] inc,
  input wire logic [7:0] pair,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [31:0] wr_val,
  output logic [15:0][31:0] cnt
);
  typedef struct packed {
    logic [15:0][31:0] cnt;
  } vcb_bank_t;

  vcb_bank_t q;
  vcb_bank_t d;

  // write wins over counting; odd half of a pair counts on even carry
  always_comb
  begin
    d = q;
    for (int k = 0; k < vcb_pkg::CNT_PER_BANK; k++)
    begin
      if (clr)
        d.cnt[k] = '0;
      else if (wr_en && wr_idx == 4'(k))
        d.cnt[k] = wr_val;
      else if (k[0] && pair[k / 2])
      begin
        if (inc[k - 1] && q.cnt[k - 1] == '1)
          d.cnt[k] = q.cnt[k] + 32'h1;
      end
      else if (inc[k])
        d.cnt[k] = q.cnt[k] + 32'h1;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign cnt = q.cnt;
endmodule // vcb_counter_bank

// >>> tb/vcb_sram_model.sv
// paging sram standing on the far side of the counter bank manager
`timescale 1ns/10ps
module vcb_sram_model (
  input wire logic clk_sys,
  input wire logic [15:0] sram_addr,
  input wire logic [31:0] sram_wdata,
  input wire logic sram_we,
  input wire logic sram_re,
  output logic [31:0] sram_rdata
);
  logic [31:0] mem [0:65535];
  // one word taken per strobed cycle; holds every inactive bank
  always @(posedge clk_sys)
  begin
    if (sram_we)
      mem[sram_addr] <= sram_wdata;
  end
  // unselected output is inverted so stale data can never pass for good
  assign sram_rdata = sram_re ? mem[sram_addr] : ~mem[sram_addr];
endmodule // vcb_sram_model

// >>> tb/virtual_counter_bank_manager_bench.sv
// self-checking bench for the virtual counter bank manager
`timescale 1ns/10ps
module virtual_counter_bank_manager_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic read_strobe_n = 1'b1;
  logic write_strobe_n = 1'b1;
  logic start_qualifier_n = 1'b1;
  logic hold_request_n = 1'b1;
  logic [13:0] addr = 14'h0;
  logic [63:0] wr_data = 64'h0;
  logic [63:0] rd_data, q;
  logic acknowledge_n, sram_we, sram_re;
  logic [15:0] sram_addr;
  logic [31:0] sram_wdata, sram_rdata;
  logic [11:0] h;
  // per-counter external events, driven by the source test
  logic [63:0] ext_ev = 64'h0;
  // small tick divider keeps the divided-source window short
  localparam int TB_DIV = 2;
  int error_cnt = 0;
  int tests_run = 0;
  int lat, cyc = 0;
  always #2 clk_sys = ~clk_sys;
  vcb_top #(.DIV(TB_DIV)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .start_qualifier_n(start_qualifier_n),
    .hold_request_n(hold_request_n), .addr(addr), .wr_data(wr_data),
    .rd_data(rd_data), .acknowledge_n(acknowledge_n), .cnt_ext(ext_ev),
    .sram_addr(sram_addr), .sram_wdata(sram_wdata), .sram_we(sram_we),
    .sram_re(sram_re), .sram_rdata(sram_rdata));
  vcb_sram_model sram_u (.clk_sys(clk_sys), .sram_addr(sram_addr),
    .sram_wdata(sram_wdata), .sram_we(sram_we), .sram_re(sram_re),
    .sram_rdata(sram_rdata));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // a hung handshake must still reach the verdict
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t run timed out", $time);
      report_and_stop();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // strobes drop at the take edge, so ack always finds them released
  task automatic acc(input logic wr, input logic [3:0] c, b, n,
    input logic [63:0] d);
    @(posedge clk_sys);
    addr <= {c, b, n, 2'b00};
    wr_data <= d;
    read_strobe_n <= wr;
    write_strobe_n <= ~wr;
    start_qualifier_n <= 1'b0;
    @(posedge clk_sys);
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    start_qualifier_n <= 1'b1;
    // lat counts clock cycles from the take edge to acknowledge
    lat = 0;
    do
    begin
      @(negedge clk_sys);
      lat++;
    end while (acknowledge_n !== 1'b0 && lat < 100);
    q = rd_data;
    chk(acknowledge_n, 0);
    @(negedge clk_sys);
    if (hold_request_n)
      chk(acknowledge_n, 1);
  endtask
  task automatic wc(input logic [3:0] b, n, input logic [31:0] v);
    acc(1, vcb_pkg::CMD_CNT, b, n, {32'ha5a5_a5a5, v});
  endtask
  task automatic rc(input logic [3:0] b, n, input logic [63:0] e);
    acc(0, vcb_pkg::CMD_CNT, b, n, 64'h0);
    chk(q, e);
  endtask
  task automatic bop(input logic [3:0] b, op, input logic [11:0] l, int e);
    acc(1, vcb_pkg::CMD_BANKOP, b, op, {52'hf_ffff_ffff_f000, l});
    chk(lat, e);
  endtask
  task automatic rb(input logic [3:0] b, input logic v, logic [11:0] l);
    acc(0, vcb_pkg::CMD_BANKREG, b, 4'h0, 64'h0);
    chk(q, {{51{1'b1}}, v, l});
  endtask
  task automatic t_basic();
    chk(rd_data, {64{1'b1}});
    for (int b = 0; b < 4; b++)
    begin
      wc(b, 4'hf, 32'h0a0b_0c00 + b);
      chk(lat, 1);
      rc(b, 4'hf, {32'hffff_ffff, 32'h0a0b_0c00 + b});
      acc(1, vcb_pkg::CMD_BANKREG, b, 4'h0, 64'hffff_f000 + 12'h3c0 + b);
      rb(b, 1'b1, 12'h3c0 + b);
    end
    $display("basic access test done");
  endtask
  task automatic t_page();
    for (int i = 0; i < 16; i++)
    begin
      wc(0, i, 32'h100 + i);
      sram_u.mem[{12'h055, 4'(i)}] = 32'hc000 + i;
      sram_u.mem[{12'h066, 4'(i)}] = 32'hd000 + i;
      sram_u.mem[{12'h3c2, 4'(i)}] = 32'h0;
    end
    bop(0, vcb_pkg::OP_STORE, 12'h0, 18);
    for (int i = 0; i < 16; i++)
      chk(sram_u.mem[{12'h3c0, 4'(i)}], 32'h100 + i);
    rc(0, 4'h7, {32'hffff_ffff, 32'h107});
    bop(1, vcb_pkg::OP_LOAD, 12'h055, 34);
    rc(1, 4'hf, {32'hffff_ffff, 32'hc00f});
    rc(1, 4'h0, {32'hffff_ffff, 32'hc000});
    for (int i = 0; i < 16; i++)
      sram_u.mem[{12'h3c0, 4'(i)}] = 32'h0;
    bop(0, vcb_pkg::OP_SWAP, 12'h066, 50);
    for (int i = 0; i < 16; i++)
    begin
      chk(sram_u.mem[{12'h3c0, 4'(i)}], 32'h100 + i);
      rc(0, i, {32'hffff_ffff, 32'hd000 + i});
    end
    rb(0, 1'b1, 12'h066);
    $display("paging test done");
  endtask
  task automatic t_inval();
    bop(2, vcb_pkg::OP_INVAL, 12'h0, 1);
    rb(2, 1'b0, 12'h3c2);
    wc(2, 4'h3, 32'h77);
    bop(2, vcb_pkg::OP_STORE, 12'h0, 1);
    chk(sram_u.mem[{12'h3c2, 4'h3}], 32'h0);
    rb(2, 1'b0, 12'h3c2);
    bop(2, vcb_pkg::OP_SWAP, 12'h055, 34);
    chk(sram_u.mem[{12'h3c2, 4'h3}], 32'h0);
    rc(2, 4'h3, {32'hffff_ffff, 32'hc003});
    rb(2, 1'b1, 12'h055);
    $display("invalidate test done");
  endtask
  task automatic t_pair();
    acc(1, vcb_pkg::CMD_CFG, 3, 0, 64'hffff_fff0 | 64'he);
    acc(0, vcb_pkg::CMD_CFG, 3, 0, 64'h0);
    chk(q, {{60{1'b1}}, 4'he});
    wc(3, 4'h0, 32'hffff_ffff);
    wc(3, 4'h1, 32'h5);
    acc(1, vcb_pkg::CMD_SWTRIG, 3, 0, 64'h0);
    rc(3, 4'h0, {32'h6, 32'h0});
    rc(3, 4'h1, {32'hffff_ffff, 32'h6});
    $display("pairing test done");
  endtask
  // each window spans six edges between the enabling and disabling takes
  task automatic t_src();
    wc(1, 4'h5, 32'h0);
    acc(1, vcb_pkg::CMD_CFG, 1, 4'h5, 64'h4);
    repeat (3) @(posedge clk_sys);
    acc(1, vcb_pkg::CMD_CFG, 1, 4'h5, 64'h0);
    rc(1, 4'h5, {32'hffff_ffff, 32'h6});
    wc(1, 4'h6, 32'h0);
    acc(1, vcb_pkg::CMD_CFG, 1, 4'h6, 64'h7);
    repeat (3) @(posedge clk_sys);
    acc(1, vcb_pkg::CMD_CFG, 1, 4'h6, 64'h0);
    rc(1, 4'h6, {32'hffff_ffff, 32'(6 / TB_DIV)});
    wc(1, 4'h4, 32'h0);
    acc(1, vcb_pkg::CMD_CFG, 1, 4'h4, 64'h5);
    // a level held high must count only once per rising edge
    repeat (3)
    begin
      @(posedge clk_sys);
      ext_ev[20] <= 1'b1;
      repeat (2) @(posedge clk_sys);
      ext_ev[20] <= 1'b0;
      @(posedge clk_sys);
    end
    repeat (2) @(posedge clk_sys);
    rc(1, 4'h4, {32'hffff_ffff, 32'h3});
    $display("counter source test done");
  endtask
  task automatic t_gen();
    for (int c = 6; c < 16; c++)
    begin
      acc(0, c, 4'h0, 4'h0, 64'h0);
      chk(q, {64{1'b1}});
    end
    h = vcb_pkg::OP_SOFT_RESET;
    acc(1, vcb_pkg::CMD_GEN, h[7:4], h[3:0], 64'h0);
    rc(3, 4'h1, {32'hffff_ffff, 32'h0});
    rb(0, 1'b1, 12'h066);
    $display("general command test done");
  endtask
  task automatic t_hs();
    @(posedge clk_sys);
    read_strobe_n <= 1'b0;
    repeat (20) @(negedge clk_sys) chk(acknowledge_n, 1);
    // pulsed qualifier under a held strobe gives one request per pulse
    repeat (2)
    begin
      @(posedge clk_sys);
      start_qualifier_n <= 1'b0;
      @(posedge clk_sys);
      start_qualifier_n <= 1'b1;
      @(negedge clk_sys);
      chk(acknowledge_n, 0);
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
    read_strobe_n <= 1'b1;
    hold_request_n <= 1'b0;
    acc(0, vcb_pkg::CMD_CNT, 0, 4'h2, 64'h0);
    chk(q, {32'hffff_ffff, 32'h0});
    repeat (3) @(negedge clk_sys) chk(acknowledge_n, 0);
    chk(rd_data, q);
    @(posedge clk_sys);
    hold_request_n <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(acknowledge_n, 1);
    $display("handshake test done");
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk(acknowledge_n, 1);
    t_basic();
    t_page();
    t_inval();
    t_pair();
    t_src();
    t_gen();
    t_hs();
    report_and_stop();
  end
endmodule // virtual_counter_bank_manager_bench
